// ==== rtl/cmpc_pkg.sv ====
// Package with register map, field layout, reset values and timing.
package cmpc_pkg;

    localparam int unsigned CLK_HZ = 20_000_000;

    // Register byte offsets.
    localparam logic [7:0] OFS_OPMODE = 8'h00;
    localparam logic [7:0] OFS_SETUP1 = 8'h04;
    localparam logic [7:0] OFS_SETUP2 = 8'h08;
    localparam logic [7:0] OFS_SYNCLEN = 8'h0c;
    localparam logic [7:0] OFS_PAYLEN = 8'h10;
    localparam logic [7:0] OFS_FIFO = 8'h14;
    localparam logic [7:0] OFS_TUNING = 8'h18;
    localparam logic [7:0] OFS_THRESH = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;

    // Field positions.
    localparam int unsigned POS_SPREAD_SEL = 7;
    localparam int unsigned POS_BW = 4;
    localparam int unsigned POS_CR = 1;
    localparam int unsigned POS_HDRLESS = 0;
    localparam int unsigned POS_SF = 4;
    localparam int unsigned POS_CRC_ON = 2;

    // Operating modes.
    localparam logic [2:0] MODE_SLEEP = 3'h0;
    localparam logic [2:0] MODE_STANDBY = 3'h1;
    localparam logic [2:0] MODE_TX = 3'h3;

    // Reset values and legal ranges.
    localparam logic [3:0] SF_MIN = 4'h6;
    localparam logic [3:0] SF_MAX = 4'hc;
    localparam logic [3:0] SF_RESET = 4'h7;
    localparam logic [2:0] CR_MIN = 3'h1;
    localparam logic [2:0] CR_MAX = 3'h4;
    localparam logic [2:0] CR_RESET = 3'h1;
    localparam logic [2:0] CR_HEADER = 3'h4;
    localparam logic [3:0] BW_MAX = 4'h9;
    localparam logic [3:0] BW_RESET = 4'h7;
    localparam logic [15:0] SYNC_MIN = 16'h0006;
    localparam logic [15:0] SYNC_RESET = 16'h000c;
    localparam logic [15:0] SYNC_FIXED = 16'h0004;
    localparam logic [7:0] PAYLEN_RESET = 8'h01;
    localparam logic [2:0] TUNING_RESET = 3'h3;
    localparam logic [7:0] THRESH_RESET = 8'h0a;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'h1021;

    // Symbol kinds on the output stream.
    localparam logic [1:0] KIND_SYNC = 2'h0;
    localparam logic [1:0] KIND_HEADER = 2'h1;
    localparam logic [1:0] KIND_PAYLOAD = 2'h2;
    localparam logic [1:0] KIND_CRC = 2'h3;

    // Double-sideband channel width in hertz for each setting code.
    function automatic int unsigned width_hz(input logic [3:0] code);
        case (code)
            4'h0: width_hz = 7_800;
            4'h1: width_hz = 10_400;
            4'h2: width_hz = 15_600;
            4'h3: width_hz = 20_800;
            4'h4: width_hz = 31_200;
            4'h5: width_hz = 41_700;
            4'h6: width_hz = 62_500;
            4'h7: width_hz = 125_000;
            4'h8: width_hz = 250_000;
            default: width_hz = 500_000;
        endcase
    endfunction : width_hz

    // Clock cycles per chip: one chip per second per hertz of width.
    function automatic logic [11:0] cycles_per_chip(input logic [3:0] code);
        int unsigned c;
        c = CLK_HZ / width_hz(code);
        cycles_per_chip = c[11:0];
    endfunction : cycles_per_chip

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SYNC = 3'b001,
        ST_HEADER = 3'b011,
        ST_PAYLOAD = 3'b010,
        ST_CRC = 3'b110,
        ST_DONE = 3'b111
    } cmpc_state_t;

endpackage : cmpc_pkg

// ==== rtl/cmpc_symbol_timer.sv ====
// Symbol strobe generator: one symbol is two to the exponent chips.
`timescale 1ns/1ps
`default_nettype none
module cmpc_symbol_timer (
    input wire logic clk, // System clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic ce, // Clock enable.
    input wire logic run, // Counts while high, restarts when low.
    input wire logic [3:0] spread_exponent, // Chips exponent.
    input wire logic [3:0] signal_width, // Width setting code.
    output logic symbol_tick // One-cycle strobe at each symbol end.
);
    logic [11:0] chip_cycle;
    logic [11:0] chip_count;
    logic [11:0] chip_last;
    logic chip_end;

    assign chip_last = cmpc_pkg::cycles_per_chip(signal_width) - 12'h001;
    assign chip_end = (chip_cycle == chip_last);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            chip_cycle <= 12'h000;
            chip_count <= 12'h000;
            symbol_tick <= 1'b0;
        end
        else if (ce)
        begin
            symbol_tick <= 1'b0;
            if (!run)
            begin
                chip_cycle <= 12'h000;
                chip_count <= 12'h000;
            end
            else if (chip_end)
            begin
                chip_cycle <= 12'h000;
                if (chip_count == ((12'h001 << spread_exponent) - 12'h001))
                begin
                    chip_count <= 12'h000;
                    symbol_tick <= 1'b1;
                end
                else
                begin
                    chip_count <= chip_count + 12'h001;
                end
            end
            else
            begin
                chip_cycle <= chip_cycle + 12'h001;
            end
        end
    end
endmodule : cmpc_symbol_timer
`default_nettype wire

// ==== rtl/cmpc_packet_config.sv ====
// Spread modem configuration registers, data buffer and packet framer.
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module cmpc_packet_config #(
    parameter int unsigned DEPTH_LOG2 = 8 // Data buffer address width.
) (
    input wire logic CLK, // System clock, 20 MHz.
    input wire logic RST, // Asynchronous reset, active high.
    input wire logic CE, // Clock enable, freezes all state when low.
    input wire logic PSEL, // APB select.
    input wire logic PENABLE, // APB enable.
    input wire logic PWRITE, // APB direction.
    input wire logic [7:0] PADDR, // APB byte address.
    input wire logic [31:0] PWDATA, // APB write data.
    output logic [31:0] PRDATA, // APB read data.
    output logic PREADY, // APB ready.
    output logic PSLVERR, // APB error on unmapped access.
    output logic SYM_VALID, // One-cycle strobe per emitted symbol.
    output logic [1:0] SYM_KIND, // Kind of emitted symbol.
    output logic [7:0] SYM_DATA, // Symbol content byte.
    output logic [2:0] SYM_RATIO, // Coding ratio used for the symbol.
    output logic TX_BUSY // High while a packet is being sent.
);
    localparam int unsigned DEPTH = 1 << DEPTH_LOG2;

    logic spread_sel;
    logic [2:0] op_mode;
    logic [3:0] signal_width;
    logic [2:0] fec_ratio_field;
    logic headerless_select_bit;
    logic [3:0] chips_exponent_field;
    logic payload_check_on;
    logic [15:0] sync_run_length;
    logic [7:0] payload_length;
    logic [2:0] detect_tuning_field;
    logic [7:0] detect_threshold_reg;
    logic [7:0] buffer [DEPTH];
    logic [DEPTH_LOG2:0] wr_ptr;
    logic [DEPTH_LOG2:0] rd_ptr;
    logic [DEPTH_LOG2:0] fill;
    cmpc_pkg::cmpc_state_t state;
    logic [15:0] sym_count;
    logic [15:0] crc;
    logic symbol_tick;
    logic acc;
    logic wr_acc;
    logic rd_acc;
    logic mapped;
    logic spread_only;
    logic start;
    logic [7:0] head_check;
    logic [31:0] rd_word;

    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++)
        begin
            r = r[15] ? ((r << 1) ^ cmpc_pkg::CRC_POLY) : (r << 1);
        end
        crc_step = r;
    endfunction : crc_step

    assign acc = PSEL && PENABLE && PREADY;
    assign wr_acc = acc && PWRITE && mapped;
    assign rd_acc = acc && !PWRITE && mapped;
    assign fill = wr_ptr - rd_ptr;
    assign start = (state == cmpc_pkg::ST_IDLE) && spread_sel
        && (op_mode == cmpc_pkg::MODE_TX);
    assign head_check = payload_length ^ {4'h0, payload_check_on,
        fec_ratio_field} ^ 8'ha5;

    // Only the mode register is visible while the spread modem is off.
    assign spread_only = (PADDR != cmpc_pkg::OFS_OPMODE);
    always_comb
    begin
        mapped = 1'b1;
        rd_word = 32'h0000_0000;
        case (PADDR)
            cmpc_pkg::OFS_OPMODE:
                rd_word = {24'h0, spread_sel, 4'h0, op_mode};
            cmpc_pkg::OFS_SETUP1:
                rd_word = {24'h0, signal_width, fec_ratio_field,
                    headerless_select_bit};
            cmpc_pkg::OFS_SETUP2:
                rd_word = {24'h0, chips_exponent_field, 1'b0,
                    payload_check_on, 2'h0};
            cmpc_pkg::OFS_SYNCLEN: rd_word = {16'h0, sync_run_length};
            cmpc_pkg::OFS_PAYLEN: rd_word = {24'h0, payload_length};
            cmpc_pkg::OFS_FIFO:
                rd_word = {24'h0, buffer[rd_ptr[DEPTH_LOG2-1:0]]};
            cmpc_pkg::OFS_TUNING: rd_word = {29'h0, detect_tuning_field};
            cmpc_pkg::OFS_THRESH: rd_word = {24'h0, detect_threshold_reg};
            cmpc_pkg::OFS_STATUS:
                rd_word = {16'h0000, state, 3'h0, 9'(fill), TX_BUSY};
            default: mapped = 1'b0;
        endcase
        if (!spread_sel && spread_only)
        begin
            mapped = 1'b0;
            rd_word = 32'h0000_0000;
        end
    end

    // Bus answer: ready one cycle into the access phase.
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end
        else if (CE)
        begin
            PREADY <= PSEL && PENABLE && !PREADY;
            PSLVERR <= PSEL && PENABLE && !PREADY && !mapped;
            if (PSEL && PENABLE && !PREADY && !PWRITE)
            begin
                PRDATA <= rd_word;
            end
        end
    end

    // Mode register; modem choice changes only from sleep.
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            spread_sel <= 1'b0;
            op_mode <= cmpc_pkg::MODE_SLEEP;
        end
        else if (CE)
        begin
            if (wr_acc && PADDR == cmpc_pkg::OFS_OPMODE)
            begin
                op_mode <= PWDATA[2:0];
                if (op_mode == cmpc_pkg::MODE_SLEEP)
                begin
                    spread_sel <= PWDATA[cmpc_pkg::POS_SPREAD_SEL];
                end
            end
            else if (state == cmpc_pkg::ST_DONE)
            begin
                op_mode <= cmpc_pkg::MODE_STANDBY;
            end
        end
    end

    // Modem configuration; out of range values leave the field unchanged.
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            signal_width <= cmpc_pkg::BW_RESET;
            fec_ratio_field <= cmpc_pkg::CR_RESET;
            headerless_select_bit <= 1'b0;
            chips_exponent_field <= cmpc_pkg::SF_RESET;
            payload_check_on <= 1'b0;
            sync_run_length <= cmpc_pkg::SYNC_RESET;
            payload_length <= cmpc_pkg::PAYLEN_RESET;
            detect_tuning_field <= cmpc_pkg::TUNING_RESET;
            detect_threshold_reg <= cmpc_pkg::THRESH_RESET;
        end
        else if (CE && wr_acc)
        begin
            case (PADDR)
                cmpc_pkg::OFS_SETUP1:
                begin
                    if (PWDATA[7:4] <= cmpc_pkg::BW_MAX)
                    begin
                        signal_width <= PWDATA[7:4];
                    end
                    if (PWDATA[3:1] >= cmpc_pkg::CR_MIN
                        && PWDATA[3:1] <= cmpc_pkg::CR_MAX)
                    begin
                        fec_ratio_field <= PWDATA[3:1];
                    end
                    headerless_select_bit <= PWDATA[0];
                end
                cmpc_pkg::OFS_SETUP2:
                begin
                    if (PWDATA[7:4] >= cmpc_pkg::SF_MIN
                        && PWDATA[7:4] <= cmpc_pkg::SF_MAX)
                    begin
                        chips_exponent_field <= PWDATA[7:4];
                    end
                    payload_check_on <= PWDATA[cmpc_pkg::POS_CRC_ON];
                end
                cmpc_pkg::OFS_SYNCLEN:
                begin
                    if (PWDATA[15:0] >= cmpc_pkg::SYNC_MIN)
                    begin
                        sync_run_length <= PWDATA[15:0];
                    end
                end
                cmpc_pkg::OFS_PAYLEN: payload_length <= PWDATA[7:0];
                cmpc_pkg::OFS_TUNING: detect_tuning_field <= PWDATA[2:0];
                cmpc_pkg::OFS_THRESH: detect_threshold_reg <= PWDATA[7:0];
                default: ;
            endcase
        end
    end

    // Data buffer: bus writes fill it, bus reads or the framer drain it.
    always_ff @(posedge CLK)
    begin
        if (CE && wr_acc && PADDR == cmpc_pkg::OFS_FIFO
            && fill != (DEPTH_LOG2 + 1)'(DEPTH))
        begin
            buffer[wr_ptr[DEPTH_LOG2-1:0]] <= PWDATA[7:0];
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            wr_ptr <= '0;
        end
        else if (CE && wr_acc && PADDR == cmpc_pkg::OFS_FIFO
            && fill != (DEPTH_LOG2 + 1)'(DEPTH))
        begin
            wr_ptr <= wr_ptr + (DEPTH_LOG2 + 1)'(1);
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            rd_ptr <= '0;
        end
        else if (CE && fill != '0)
        begin
            if ((rd_acc && PADDR == cmpc_pkg::OFS_FIFO)
                || (symbol_tick && state == cmpc_pkg::ST_PAYLOAD))
            begin
                rd_ptr <= rd_ptr + (DEPTH_LOG2 + 1)'(1);
            end
        end
    end

    cmpc_symbol_timer u_timer (
        .clk(CLK),
        .rst(RST),
        .ce(CE),
        .run(TX_BUSY),
        .spread_exponent(chips_exponent_field),
        .signal_width(signal_width),
        .symbol_tick(symbol_tick)
    );

    // Framer: sync run, optional header, payload, optional check.
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            state <= cmpc_pkg::ST_IDLE;
            sym_count <= 16'h0000;
            crc <= cmpc_pkg::CRC_INIT;
            TX_BUSY <= 1'b0;
            SYM_VALID <= 1'b0;
            SYM_KIND <= cmpc_pkg::KIND_SYNC;
            SYM_DATA <= 8'h00;
            SYM_RATIO <= cmpc_pkg::CR_RESET;
        end
        else if (CE)
        begin
            SYM_VALID <= 1'b0;
            case (state)
                cmpc_pkg::ST_IDLE:
                begin
                    if (start)
                    begin
                        state <= cmpc_pkg::ST_SYNC;
                        sym_count <= 16'h0000;
                        crc <= cmpc_pkg::CRC_INIT;
                        TX_BUSY <= 1'b1;
                    end
                end
                cmpc_pkg::ST_SYNC:
                begin
                    if (symbol_tick)
                    begin
                        SYM_VALID <= 1'b1;
                        SYM_KIND <= cmpc_pkg::KIND_SYNC;
                        SYM_DATA <= 8'h00;
                        SYM_RATIO <= fec_ratio_field;
                        sym_count <= sym_count + 16'h0001;
                        // Run is programmed count plus the fixed tail.
                        if ({1'b0, sym_count} == {1'b0, sync_run_length}
                            + {1'b0, cmpc_pkg::SYNC_FIXED} - 17'h00001)
                        begin
                            sym_count <= 16'h0000;
                            state <= headerless_select_bit
                                ? cmpc_pkg::ST_PAYLOAD
                                : cmpc_pkg::ST_HEADER;
                        end
                    end
                end
                cmpc_pkg::ST_HEADER:
                begin
                    if (symbol_tick)
                    begin
                        SYM_VALID <= 1'b1;
                        SYM_KIND <= cmpc_pkg::KIND_HEADER;
                        SYM_RATIO <= cmpc_pkg::CR_HEADER;
                        sym_count <= sym_count + 16'h0001;
                        case (sym_count[1:0])
                            2'h0: SYM_DATA <= payload_length;
                            2'h1: SYM_DATA <= {4'h0, payload_check_on,
                                fec_ratio_field};
                            default:
                            begin
                                SYM_DATA <= head_check;
                                sym_count <= 16'h0000;
                                state <= cmpc_pkg::ST_PAYLOAD;
                            end
                        endcase
                    end
                end
                cmpc_pkg::ST_PAYLOAD:
                begin
                    if (symbol_tick)
                    begin
                        SYM_VALID <= 1'b1;
                        SYM_KIND <= cmpc_pkg::KIND_PAYLOAD;
                        SYM_RATIO <= fec_ratio_field;
                        SYM_DATA <= buffer[rd_ptr[DEPTH_LOG2-1:0]];
                        crc <= crc_step(crc,
                            buffer[rd_ptr[DEPTH_LOG2-1:0]]);
                        sym_count <= sym_count + 16'h0001;
                        if (sym_count[7:0] == payload_length - 8'h01)
                        begin
                            sym_count <= 16'h0000;
                            state <= payload_check_on ? cmpc_pkg::ST_CRC
                                : cmpc_pkg::ST_DONE;
                        end
                    end
                end
                cmpc_pkg::ST_CRC:
                begin
                    if (symbol_tick)
                    begin
                        SYM_VALID <= 1'b1;
                        SYM_KIND <= cmpc_pkg::KIND_CRC;
                        SYM_RATIO <= fec_ratio_field;
                        sym_count <= sym_count + 16'h0001;
                        if (sym_count[0] == 1'b0)
                        begin
                            SYM_DATA <= crc[15:8];
                        end
                        else
                        begin
                            SYM_DATA <= crc[7:0];
                            sym_count <= 16'h0000;
                            state <= cmpc_pkg::ST_DONE;
                        end
                    end
                end
                cmpc_pkg::ST_DONE:
                begin
                    TX_BUSY <= 1'b0;
                    state <= cmpc_pkg::ST_IDLE;
                end
                default: state <= cmpc_pkg::ST_IDLE;
            endcase
        end
    end
endmodule : cmpc_packet_config
`default_nettype wire

// ==== sim/cmpc_props.sv ====
// Concurrent checks on the bus and framer ports.
`timescale 1ns/1ps
`default_nettype none
module cmpc_props (
    input wire logic CLK, // Clock.
    input wire logic RST, // Reset.
    input wire logic PSEL, // Select.
    input wire logic PENABLE, // Enable.
    input wire logic [7:0] PADDR, // Address.
    input wire logic PREADY, // Ready.
    input wire logic PSLVERR, // Error.
    input wire logic SYM_VALID, // Strobe.
    input wire logic [1:0] SYM_KIND, // Kind.
    input wire logic [7:0] SYM_DATA, // Data.
    input wire logic [2:0] SYM_RATIO, // Ratio.
    input wire logic TX_BUSY // Busy.
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    a_one_wait: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY)
        else $error("ready not after one wait");
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready held");
    a_err_ready: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    a_unmapped_err: assert property (PREADY && PADDR > 8'h20
        |-> PSLVERR)
        else $error("unmapped access not refused");
    a_sym_pulse: assert property (SYM_VALID |=> !SYM_VALID [*8])
        else $error("symbol strobes too close");
    a_sym_busy: assert property (SYM_VALID |-> TX_BUSY)
        else $error("symbol outside packet");
    a_hdr_ratio: assert property (SYM_VALID && SYM_KIND == 2'h1
        |-> SYM_RATIO == 3'h4)
        else $error("header ratio wrong");
    a_ratio_range: assert property (SYM_VALID
        |-> SYM_RATIO inside {[3'h1:3'h4]})
        else $error("ratio out of range");
    a_sync_zero: assert property (SYM_VALID && SYM_KIND == 2'h0
        |-> SYM_DATA == 8'h00)
        else $error("sync symbol not zero");
endmodule : cmpc_props
bind cmpc_packet_config cmpc_props u_props (.CLK(CLK), .RST(RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SYM_VALID(SYM_VALID), .SYM_KIND(SYM_KIND),
    .SYM_DATA(SYM_DATA), .SYM_RATIO(SYM_RATIO), .TX_BUSY(TX_BUSY));
`default_nettype wire

// ==== sim/cmpc_peer.sv ====
// Remote peer model that tallies the received symbol stream.
`timescale 1ns/1ps
`default_nettype none
module cmpc_peer (
    input wire logic clk, // Clock.
    input wire logic rst, // Reset.
    input wire logic clr, // Clears tallies.
    input wire logic sym_valid, // Strobe.
    input wire logic [1:0] sym_kind, // Kind.
    input wire logic [7:0] sym_data, // Data.
    input wire logic [2:0] sym_ratio, // Ratio.
    output logic [7:0] cnt [4], // Symbols per kind.
    output logic [2:0] ratio [4], // Last ratio per kind.
    output logic [7:0] last [4], // Last data byte per kind.
    output logic [15:0] gap // Cycles between strobes.
);
    logic [15:0] run;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst || clr)
        begin
            cnt <= '{default: 8'h00};
            ratio <= '{default: 3'h0};
            last <= '{default: 8'h00};
        end
        else if (sym_valid)
        begin
            cnt[sym_kind] <= cnt[sym_kind] + 8'h01;
            ratio[sym_kind] <= sym_ratio;
            last[sym_kind] <= sym_data;
        end
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            run <= 16'h0001;
            gap <= 16'h0000;
        end
        else if (sym_valid)
        begin
            gap <= run;
            run <= 16'h0001;
        end
        else
            run <= run + 16'h0001;
    end
endmodule : cmpc_peer
`default_nettype wire

// ==== sim/cmpc_packet_config_tb_top.sv ====
// Self-checking bench for the packet configuration block.
`timescale 1ns/1ps
`default_nettype none
module cmpc_packet_config_tb_top;
    logic CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, clr = 0;
    logic ce = 1;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, q;
    logic PREADY, PSLVERR, SYM_VALID, TX_BUSY, e;
    logic [1:0] SYM_KIND;
    logic [7:0] SYM_DATA;
    logic [7:0] last [4];
    logic [2:0] SYM_RATIO;
    logic [7:0] cnt [4];
    logic [2:0] ratio [4];
    logic [15:0] gap;
    int err_count = 0, num_checks = 0;
    always #25 CLK = ~CLK;
    cmpc_packet_config dut (.CLK(CLK), .RST(RST), .CE(ce), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .SYM_VALID(SYM_VALID), .SYM_KIND(SYM_KIND),
        .SYM_DATA(SYM_DATA), .SYM_RATIO(SYM_RATIO), .TX_BUSY(TX_BUSY));
    cmpc_peer peer (.clk(CLK), .rst(RST), .clr(clr), .sym_valid(SYM_VALID),
        .sym_kind(SYM_KIND), .sym_data(SYM_DATA), .sym_ratio(SYM_RATIO),
        .cnt(cnt), .ratio(ratio), .last(last), .gap(gap));
    task automatic summarize;
        if (err_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize
    task automatic chk(input string n, input logic [31:0] s, x);
        num_checks++;
        if (s !== x)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int i;
        @(posedge CLK);
        PSEL <= 1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge CLK);
            if (PREADY === 1'b1)
                break;
        end
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 0;
        PENABLE <= 0;
        if (i == 20)
        begin
            err_count++;
            summarize();
        end
    endtask : apb
    task automatic t_map;
        logic [31:0] rv [8] = '{0, 'h72, 'h70, 'hc, 'h1, 0, 'h3, 'ha};
        apb(0, 8'h04, 0);
        chk("map off", {31'h0, e}, 1);
        apb(1, 8'h00, 32'h80);
        for (int i = 1; i < 8; i++)
            if (i != 5)
            begin
                apb(0, 8'(i * 4), 0);
                chk("reset", q, rv[i]);
            end
        apb(0, 8'h24, 0);
        chk("unmapped", {q[30:0], e}, 1);
    endtask : t_map
    task automatic t_range;
        logic [7:0] ta [11] = '{8, 8, 8, 4, 4, 4, 4, 'hc, 'hc, 'h18, 'h1c};
        logic [7:0] tw [11] = '{'h50, 'hd0, 'h60, 'h70, 'h7a, 'ha2, 'h98,
            5, 6, 5, 'hc};
        logic [7:0] tx [11] = '{'h70, 'h70, 'h60, 'h72, 'h72, 'h72, 'h98,
            'hc, 6, 5, 'hc};
        for (int i = 0; i < 11; i++)
        begin
            apb(1, ta[i], tw[i]);
            apb(0, ta[i], 0);
            chk("field", q, tx[i]);
        end
    endtask : t_range
    task automatic t_tx(input logic hl, input logic [7:0] sf, b);
        int i;
        apb(1, 8'h08, sf);
        // Detection settings follow the exponent, as the host must keep them.
        apb(1, 8'h18, sf[7:4] == 4'h6 ? 32'h5 : 32'h3);
        apb(1, 8'h1c, sf[7:4] == 4'h6 ? 32'hc : 32'ha);
        // The widest width is allowed in the band this host works in.
        apb(1, 8'h04, 8'h92 | hl);
        apb(1, 8'h14, b);
        clr <= 1;
        @(posedge CLK);
        clr <= 0;
        apb(1, 8'h00, 32'h83);
        ce <= 0;
        repeat (3) @(posedge CLK);
        chk("frozen", TX_BUSY, 0);
        ce <= 1;
        apb(0, 8'h20, 0);
        chk("status", q, 32'h2003);
        for (i = 0; i < 80000 && TX_BUSY !== 1'b0; i++)
            @(posedge CLK);
        if (i == 80000)
        begin
            err_count++;
            summarize();
        end
        chk("sync", cnt[0], 10);
        chk("header", cnt[1], hl ? 0 : 3);
        chk("payload", cnt[2], 1);
        chk("byte", last[2], b);
        chk("hcheck", last[1], hl ? 0 : 8'ha5);
        chk("hratio", ratio[1], hl ? 0 : 4);
        chk("pratio", ratio[2], 1);
        chk("period", gap, 40 << sf[7:4]);
        apb(0, 8'h00, 0);
        chk("mode", q, 32'h81);
    endtask : t_tx
    initial
    begin
        repeat (8) @(posedge CLK);
        RST <= 0;
        t_map();
        t_range();
        t_tx(0, 8'h70, 8'h5a);
        t_tx(1, 8'h60, 8'ha5);
        summarize();
    end
endmodule : cmpc_packet_config_tb_top
`default_nettype wire
